// [hdl/clock_gater.v]
`timescale 1ns/10ps
`include "thermal_defs.vh"
module clock_gater
  (
    // Clock and reset
    input  wire sys_clk_i,
    input  wire rst_i,
    // Control
    input  wire gate_en_i,
    // Gate output, high while the core clock may run
    output wire core_clk_en_o
  );

  reg  [3:0] phase_r;
  reg  [3:0] phase_nxt;
  reg        run_r;

  // Phase counter wraps every gating period
  always @*
  begin
    if (phase_r == `GATE_PERIOD - 4'h1)
      phase_nxt = 4'h0;
    else
      phase_nxt = phase_r + 4'h1;
  end

  // Registered enable; full run when gating is off
  always @(posedge sys_clk_i)
  begin
    if (rst_i || !gate_en_i)
    begin
      phase_r <= 4'h0;
      run_r   <= 1'b1;
    end
    else
    begin
      phase_r <= phase_nxt;
      run_r   <= (phase_nxt < `GATE_ON);
    end
  end

  assign core_clk_en_o = run_r;

endmodule

// [hdl/thermal_defs.vh]
// Function
// - Three die sensors, two for processor cores, one for graphics/memory die, readable.
// - Sensor reading returned to software saturates at maximum operating temperature.
// - Above fixed activation threshold, reduce power until at or below maximum.
// - Control circuit picks frequency/voltage stepping or clock gating by itself.
// - Step ratio and voltage code down together, repeat until minimum or cooled.
// - Still hot at minimum frequency: start core clock gating, hold minimum.
// - Clock gating runs core clock for a 30 to 50 percent duty cycle.
// - Below maximum operating temperature the control deactivates and gating stops.
// - Halt all execution when junction temperature exceeds about 125 degrees.
// - Catastrophic trip stays latched until a full power-on restart.
// - Catastrophic trip protection is always enabled, firmware cannot disable it.
// - Indicator steady red when processor above 105 or graphics die above 100 (code: only while boot_done_i is high).
// - Indicator blinks red at a regular interval when processor above 125.
`ifndef THERMAL_DEFS_VH
`define THERMAL_DEFS_VH

// Temperatures in whole degrees C, 8-bit
`define TEMP_W              8
`define PROC_MAX_TEMP       8'h69
`define GFX_MAX_TEMP        8'h64
`define TRIP_TEMP           8'h7D
// Core ratio and voltage code
`define RATIO_W             6
`define VID_W               7
`define RATIO_MAX           6'h19
`define RATIO_MIN           6'h07
`define VID_MAX             7'h3C
`define VID_STEP            7'h02
// Timing: step dwell in ns and blink half-period in ms at 200 MHz
`define CLK_PERIOD_NS       5
`define STEP_DWELL_NS       10000
`define BLINK_HALF_MS       250
// Gating period of 8 cycles, clock runs 3 of them (37.5 percent)
`define GATE_PERIOD         4'h8
`define GATE_ON             4'h3

`endif

// [hdl/thermal_supervision_control.v]
`timescale 1ns/10ps
`include "thermal_defs.vh"
module thermal_supervision_control
  #(
    parameter DWELL_CYCLES = (`STEP_DWELL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter BLINK_CYCLES = `BLINK_HALF_MS * 1000000 / `CLK_PERIOD_NS
  )
  (
    // Clock and resets
    input  wire                 sys_clk_i,
    input  wire                 rst_i,
    input  wire                 por_i,
    // Raw die sensor readings
    input  wire [`TEMP_W-1:0]   core0_temp_i,
    input  wire [`TEMP_W-1:0]   core1_temp_i,
    input  wire [`TEMP_W-1:0]   gfx_temp_i,
    // Firmware control
    input  wire                 tcc_enable_i,
    input  wire                 boot_done_i,
    input  wire [1:0]           sensor_sel_i,
    // Saturated sensor value for software
    output reg  [`TEMP_W-1:0]   sensor_rdata_o,
    // Core clock and regulator
    output wire [`RATIO_W-1:0]  core_ratio_o,
    output wire [`VID_W-1:0]    voltage_id_code_o,
    output wire                 core_clk_en_o,
    output wire                 tcc_active_o,
    output wire                 halt_o,
    output wire                 catastrophic_trip_n_o,
    // Front-panel indicator
    output wire                 thermal_indicator_o
  );

  // Control states: idle, frequency and voltage stepping, clock gating
  localparam ST_IDLE  = 2'h0;
  localparam ST_STEP  = 2'h1;
  localparam ST_GATE  = 2'h2;

  // Larger of two readings
  function [`TEMP_W-1:0] tmax;
    input [`TEMP_W-1:0] a;
    input [`TEMP_W-1:0] b;
    begin
      tmax = (a > b) ? a : b;
    end
  endfunction

  // Clamp to a limit
  function [`TEMP_W-1:0] tsat;
    input [`TEMP_W-1:0] t;
    input [`TEMP_W-1:0] lim;
    begin
      tsat = (t > lim) ? lim : t;
    end
  endfunction

  // Control loop state
  reg  [1:0]           state_r;
  reg  [1:0]           state_nxt;
  reg  [`RATIO_W-1:0]  ratio_r;
  reg  [`RATIO_W-1:0]  ratio_nxt;
  reg  [`VID_W-1:0]    vid_r;
  reg  [`VID_W-1:0]    vid_nxt;
  reg  [31:0]          dwell_r;
  // Trip latch and indicator timing
  reg                  trip_r;
  reg  [31:0]          blink_cnt_r;
  reg                  blink_r;
  reg                  hot_r;
  reg                  trip_hot_r;

  // Conditions derived from the sensor readings and the dwell counter
  wire [`TEMP_W-1:0]   proc_temp;
  wire                 over_thr;
  wire                 at_or_below;
  wire                 dwell_done;
  wire                 steady_red;

  // Hottest processor core drives the control loop
  assign proc_temp   = tmax(core0_temp_i, core1_temp_i);
  assign over_thr    = (proc_temp > `PROC_MAX_TEMP);
  assign at_or_below = !over_thr;
  assign dwell_done  = (dwell_r == 32'h0);

  // Software read mux with saturation per die limit
  // Select 3 reads zero; there is no fourth sensor behind it
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      sensor_rdata_o <= 8'h00;
    else
    begin
      case (sensor_sel_i)
        2'h0:    sensor_rdata_o <= tsat(core0_temp_i, `PROC_MAX_TEMP);
        2'h1:    sensor_rdata_o <= tsat(core1_temp_i, `PROC_MAX_TEMP);
        2'h2:    sensor_rdata_o <= tsat(gfx_temp_i, `GFX_MAX_TEMP);
        default: sensor_rdata_o <= 8'h00;
      endcase
    end
  end

  // Control circuit state machine picks its own method
  // Gating is tried only once stepping has reached the minimum ratio
  always @*
  begin
    state_nxt = state_r;
    ratio_nxt = ratio_r;
    vid_nxt   = vid_r;
    case (state_r)
      ST_IDLE:
      begin
        // Full ratio and voltage code while the loop is idle
        ratio_nxt = `RATIO_MAX;
        vid_nxt   = `VID_MAX;
        if (tcc_enable_i && over_thr)
          state_nxt = ST_STEP;
      end
      ST_STEP:
      begin
        if (!tcc_enable_i || at_or_below)
          state_nxt = ST_IDLE;
        else if (dwell_done)
        begin
          if (ratio_r == `RATIO_MIN)
            state_nxt = ST_GATE;
          else
          begin
            // Ratio and voltage code move together
            ratio_nxt = ratio_r - 6'h01;
            vid_nxt   = vid_r - `VID_STEP;
          end
        end
      end
      ST_GATE:
      begin
        // Hold minimum ratio; gating runs in the gater below
        if (!tcc_enable_i || at_or_below)
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Dwell between steps lets the die respond before the next decision
  // A shorter dwell reacts faster but may step past the point where the die cools
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      ratio_r <= `RATIO_MAX;
      vid_r   <= `VID_MAX;
      dwell_r <= 32'h0;
    end
    else
    begin
      state_r <= state_nxt;
      ratio_r <= ratio_nxt;
      vid_r   <= vid_nxt;
      if (state_r == ST_IDLE || dwell_done)
        dwell_r <= DWELL_CYCLES;
      else
        dwell_r <= dwell_r - 32'h1;
    end
  end

  // Catastrophic trip: cleared only by power-on reset, never by rst_i or firmware
  // A warm reset must not free a halted die, so rst_i has no term here
  // The latch is unknown until por_i is seen, so raise it with rst_i at power-up
  always @(posedge sys_clk_i)
  begin
    if (por_i)
      trip_r <= 1'b0;
    else if (proc_temp > `TRIP_TEMP)
      trip_r <= 1'b1;
  end

  // Blink timer and indicator conditions
  // The blink timer runs free, so the first blink after a trip may be short
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      blink_cnt_r <= 32'h0;
      blink_r     <= 1'b0;
      hot_r       <= 1'b0;
      trip_hot_r  <= 1'b0;
    end
    else
    begin
      if (blink_cnt_r == BLINK_CYCLES - 1)
      begin
        blink_cnt_r <= 32'h0;
        blink_r     <= !blink_r;
      end
      else
        blink_cnt_r <= blink_cnt_r + 32'h1;
      hot_r      <= boot_done_i && (over_thr || gfx_temp_i > `GFX_MAX_TEMP);
      trip_hot_r <= (proc_temp > `TRIP_TEMP) || trip_r;
    end
  end

  // Steady red waits for boot done; the trip blink does not
  assign steady_red = hot_r;
  // Blinking wins over steady red
  // so a halted die is never shown as merely warm
  assign thermal_indicator_o = trip_hot_r ? blink_r : steady_red;

  // Gater shares rst_i so gating stops at once on a warm reset
  clock_gater u_gater
  (
    .sys_clk_i     (sys_clk_i),
    .rst_i         (rst_i),
    .gate_en_i     (state_r == ST_GATE),
    .core_clk_en_o (core_clk_en_o)
  );

  // Ratio, voltage code and trip come straight from flip-flops
  assign core_ratio_o          = ratio_r;
  assign voltage_id_code_o     = vid_r;
  assign tcc_active_o          = (state_r != ST_IDLE);
  assign halt_o                = trip_r;
  assign catastrophic_trip_n_o = !trip_r;

endmodule

// [sim/core_clock_model.sv]
`timescale 1ns/10ps
module core_clock_model
  (
    // Board clock and gate
    input  wire        sys_clk_i,
    input  wire        clk_en_i,
    // Core clock cycles let through
    output reg  [15:0] ticks_o
  );
  // Counts only gated-through cycles, so duty shows as a count
  initial ticks_o = 16'h0000;
  always @(posedge sys_clk_i)
    if (clk_en_i)
      ticks_o <= ticks_o + 16'h0001;
endmodule

// [sim/testbench.sv]
`timescale 1ns/10ps
`include "thermal_defs.vh"
module testbench;
  reg sys_clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, en = 1'b0, boot = 1'b0;
  reg [7:0] c0 = 8'h14, c1 = 8'h14, gfx = 8'h14;
  reg [1:0] sel = 2'h0;
  reg [31:0] lfsr = 32'h53BF;
  reg [15:0] t0 = 16'h0000;
  wire [7:0] rdata;
  wire [5:0] ratio;
  wire [6:0] voltage_id_code;
  wire clk_en, act, halt, trip_n, ind;
  wire [15:0] ticks;
  integer fail_count = 0, n_tests = 0, cyc = 0;
  typedef struct {int id; logic [7:0] v;} note_t;
  note_t q[$];
  thermal_supervision_control #(.DWELL_CYCLES(4), .BLINK_CYCLES(8)) u_thermal_supervision_control (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .por_i(por_i), .core0_temp_i(c0), .core1_temp_i(c1),
    .gfx_temp_i(gfx), .tcc_enable_i(en), .boot_done_i(boot), .sensor_sel_i(sel), .sensor_rdata_o(rdata),
    .core_ratio_o(ratio), .voltage_id_code_o(voltage_id_code), .core_clk_en_o(clk_en), .tcc_active_o(act),
    .halt_o(halt), .catastrophic_trip_n_o(trip_n), .thermal_indicator_o(ind));
  core_clock_model u_core_clock_model (.sys_clk_i(sys_clk_i), .clk_en_i(clk_en), .ticks_o(ticks));
  // Clock and a hang limit well above the few hundred cycles needed
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      fail_count = fail_count + 1;
      end_of_test;
    end
  end
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [7:0] sat(input [31:0] s);
    case (s[25:24])
      2'h0: sat = (s[7:0] > `PROC_MAX_TEMP) ? `PROC_MAX_TEMP : s[7:0];
      2'h1: sat = (s[15:8] > `PROC_MAX_TEMP) ? `PROC_MAX_TEMP : s[15:8];
      2'h2: sat = (s[23:16] > `GFX_MAX_TEMP) ? `GFX_MAX_TEMP : s[23:16];
      default: sat = 8'h00;
    endcase
  endfunction
  function [7:0] obs(input integer id);
    case (id)
      0: obs = rdata;
      1: obs = {2'h0, ratio};
      2: obs = {1'h0, voltage_id_code};
      3: obs = {7'h00, halt};
      4: obs = {7'h00, trip_n};
      5: obs = {7'h00, ind};
      6: obs = {7'h00, act};
      7: obs = {7'h00, clk_en};
      default: obs = ticks[7:0] - t0[7:0];
    endcase
  endfunction
  // Printable name of each observed result
  function string nm(input integer id);
    case (id)
      0: nm = "sensor_rdata_o";
      1: nm = "core_ratio_o";
      2: nm = "voltage_id_code_o";
      3: nm = "halt_o";
      4: nm = "catastrophic_trip_n_o";
      5: nm = "thermal_indicator_o";
      6: nm = "tcc_active_o";
      7: nm = "core_clk_en_o";
      default: nm = "core_clock_ticks";
    endcase
  endfunction
  task tick(input integer n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // Waits on pre-edge values, so it never races the design's updates
  task await(input integer id, input [7:0] v);
    while (obs(id) !== v) @(posedge sys_clk_i);
  endtask
  task note(input integer id, input [7:0] v);
    q.push_back('{id, v});
  endtask
  task cmp(input note_t e);
    begin
      n_tests = n_tests + 1;
      if (obs(e.id) !== e.v)
      begin
        fail_count = fail_count + 1;
        $display("[FAIL] %s exp %h got %h", nm(e.id), e.v, obs(e.id));
      end
    end
  endtask
  // Results are read mid-cycle, after the edge's updates have landed
  always @(negedge sys_clk_i)
    while (q.size() > 0)
      cmp(q.pop_front());
  task end_of_test;
    begin
      if (fail_count == 0 && n_tests > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial
  begin
    tick(20);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    en <= 1'b1;
    c0 <= 8'h6E;
    tick(2);
    note(6, 8'h01);
    await(1, 8'h18);
    note(2, 8'h3A);
    await(1, 8'h07);
    note(2, 8'h18);
    await(7, 8'h00);
    t0 = ticks;
    tick(79);
    note(8, 8'h1E);
    note(1, 8'h07);
    c0 <= 8'h69;
    await(6, 8'h00);
    tick(2);
    note(7, 8'h01);
    note(1, 8'h19);
    boot <= 1'b1;
    gfx <= 8'h65;
    tick(2);
    note(5, 8'h01);
    gfx <= 8'h64;
    c1 <= 8'h6A;
    tick(2);
    note(5, 8'h01);
    boot <= 1'b0;
    tick(2);
    note(5, 8'h00);
    boot <= 1'b1;
    en <= 1'b0;
    gfx <= 8'h65;
    c1 <= 8'h7E;
    tick(2);
    note(3, 8'h01);
    note(4, 8'h00);
    await(5, 8'h00);
    await(5, 8'h01);
    tick(6);
    note(5, 8'h01);
    tick(1);
    note(5, 8'h00);
    c1 <= 8'h14;
    gfx <= 8'h14;
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(2);
    note(3, 8'h01);
    por_i <= 1'b1;
    tick(2);
    por_i <= 1'b0;
    tick(2);
    note(4, 8'h01);
    repeat (12)
    begin
      lfsr = nxt(lfsr);
      c0 <= lfsr[7:0];
      c1 <= lfsr[15:8];
      gfx <= lfsr[23:16];
      sel <= lfsr[25:24];
      tick(2);
      note(0, sat(lfsr));
    end
    tick(2);
    end_of_test;
  end
endmodule
bind thermal_supervision_control thermal_checker u_thermal_checker (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .por_i(por_i), .core0_temp_i(core0_temp_i),
  .core1_temp_i(core1_temp_i), .gfx_temp_i(gfx_temp_i), .tcc_enable_i(tcc_enable_i),
  .boot_done_i(boot_done_i), .sensor_sel_i(sensor_sel_i), .sensor_rdata_o(sensor_rdata_o),
  .core_ratio_o(core_ratio_o), .voltage_id_code_o(voltage_id_code_o), .core_clk_en_o(core_clk_en_o),
  .tcc_active_o(tcc_active_o), .halt_o(halt_o), .catastrophic_trip_n_o(catastrophic_trip_n_o),
  .thermal_indicator_o(thermal_indicator_o));

// [sim/thermal_checker.sv]
`timescale 1ns/10ps
`include "thermal_defs.vh"
module thermal_checker
  (
    // Clock and resets
    input wire               sys_clk_i,
    input wire               rst_i,
    input wire               por_i,
    // Sensor and firmware inputs
    input wire [`TEMP_W-1:0]  core0_temp_i,
    input wire [`TEMP_W-1:0]  core1_temp_i,
    input wire [`TEMP_W-1:0]  gfx_temp_i,
    input wire               tcc_enable_i,
    input wire               boot_done_i,
    input wire [1:0]         sensor_sel_i,
    // Design outputs
    input wire [`TEMP_W-1:0]  sensor_rdata_o,
    input wire [`RATIO_W-1:0] core_ratio_o,
    input wire [`VID_W-1:0]   voltage_id_code_o,
    input wire               core_clk_en_o,
    input wire               tcc_active_o,
    input wire               halt_o,
    input wire               catastrophic_trip_n_o,
    input wire               thermal_indicator_o
  );
  // The halt set and hold checks override this with the power-on reset, which alone clears a trip
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire hot_proc = core0_temp_i > `TRIP_TEMP || core1_temp_i > `TRIP_TEMP;

  AST_TRIP_PIN: assert property (catastrophic_trip_n_o == !halt_o)
    else $error("trip pin disagrees with halt");
  AST_HALT_SET: assert property (disable iff (por_i) hot_proc |=> halt_o)
    else $error("no halt after trip temperature");
  AST_HALT_HOLD: assert property (disable iff (por_i) halt_o |=> halt_o)
    else $error("halt cleared without power-on reset");
  AST_RDATA_SAT: assert property (sensor_rdata_o <= `PROC_MAX_TEMP)
    else $error("sensor value above limit");
  AST_RDATA_GFX: assert property (sensor_sel_i == 2'h2 |=> sensor_rdata_o <= `GFX_MAX_TEMP)
    else $error("graphics reading above its limit");
  AST_STEP_PAIR: assert property ($changed(core_ratio_o) |-> $changed(voltage_id_code_o))
    else $error("ratio changed without voltage code");
  AST_GATE_MIN: assert property (!core_clk_en_o |-> core_ratio_o == `RATIO_MIN)
    else $error("gating above minimum ratio");
  AST_IDLE_CLK: assert property (!tcc_active_o [*2] |-> core_clk_en_o)
    else $error("gating while control inactive");
  AST_DUTY: assert property (!core_clk_en_o [*5] |=> core_clk_en_o)
    else $error("core clock off too long");
  AST_ACTIVATE: assert property (tcc_enable_i && core0_temp_i > `PROC_MAX_TEMP |=> tcc_active_o)
    else $error("control not active when hot");
  AST_STEADY: assert property (boot_done_i && gfx_temp_i > `GFX_MAX_TEMP && !hot_proc && !halt_o
    |=> thermal_indicator_o)
    else $error("indicator dark while die hot");
endmodule
